// *** pci_err_cfg.svh ***
// Purpose: Shared constants of the PCI arbitration and error-report agent
// Assumes: Included by the package and by the design modules
// Notes: Timing figures are in PCI clocks of 10 ns
`ifndef PCI_ERR_CFG_SVH
`define PCI_ERR_CFG_SVH

// Bus widths
`define PCI_AD_W 32
`define PCI_CBE_W 4

// Input synchroniser depth for the asynchronous bus reset pin
`define SYNC_STAGES 3

// Pull-up restore time of the open-drain system error line, in clocks
`define SERR_PULLUP_CLKS 3
`define SERR_GAP_W 2

// Reset value of the sampled bus pins: everything idle (high)
`define BUS_IDLE_BIT 1'b1

`endif

// *** pci_err_pkg.sv ***
// Purpose: Types of the PCI arbitration and error-report agent
// Assumes: pci_err_cfg.svh gives widths
// Notes: Pin groups travel as packed structs
`include "pci_err_cfg.svh"

package pci_err_pkg;

    // Bused pins sampled on the PCI clock
    typedef struct packed {
        logic [`PCI_AD_W-1:0] ad;
        logic [`PCI_CBE_W-1:0] cbe_n;
        logic par;
        logic irdy_n;
        logic trdy_n;
        logic gnt_n;
    } bus_in_s;

    // Pin drivers: value and output enable of each driven pin
    typedef struct packed {
        logic req_n;
        logic req_oe;
        logic devsel_n;
        logic devsel_oe;
        logic perr_n;
        logic perr_oe;
        logic serr_n;
        logic serr_oe;
    } pin_out_s;

    // Sustained tri-state driver sequence
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH
    } sts_state_e;

endpackage

// *** pci_err_sync.sv ***
// Purpose: Three-stage synchroniser for one asynchronous pin
// Assumes: Output starts low under reset
// Notes: Output follows only once stages two and three agree
`include "pci_err_cfg.svh"

module pci_err_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Asynchronous pin and filtered level
    input wire logic i_async,
    output logic o_level
);

    logic [`SYNC_STAGES-1:0] stage_r;
    logic [`SYNC_STAGES-1:0] stage_nxt;
    logic level_r;
    logic level_nxt;

    // Shift in; the first stage feeds only the second
    always_comb begin
        stage_nxt = {stage_r[`SYNC_STAGES-2:0], i_async};
        level_nxt = level_r;
        if (stage_r[1] == stage_r[2]) begin
            level_nxt = stage_r[2];
        end
    end

    // Registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage_r <= '0;
            level_r <= 1'b0;
        end else begin
            stage_r <= stage_nxt;
            level_r <= level_nxt;
        end
    end

    assign o_level = level_r;

endmodule

// *** pci_err_agent.sv ***
// Purpose: Bus-master request and error-report pins of a PCI agent
// Assumes: Bus pins are synchronous to i_clk; bus reset pin is not
// Notes: User qualifiers are read in the cycle after the bus edge
// How it works
// - Own request and grant lines; request floats while bus reset holds.
// - Grant input ignored during bus reset; nothing starts from it.
// - Parity error pin only for data parity, never for special cycles.
// - Receiver drives parity error two clocks after the erroneous data.
// - Parity error held one clock per bad phase, continuous over runs.
// - Parity error driven high one clock before it floats, except when bus reset floats it at once.
// - Every data parity error reported on time, never dropped or delayed.
// - Report only as claiming target after a phase, or as master.
// - System error covers address parity, special-cycle parity, fatal faults.
// - System error driven low exactly one clock, never driven high.
// - System error changes only on clock edges.
// - System error returns high by pull-up within three clocks.
// - Both error outputs exist; each asserts only when enabled.
// - Data phase completes when both ready signals are sampled low.
// - Target claims an access by driving device select.
`include "pci_err_cfg.svh"

module pci_err_agent
    import pci_err_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Bus pins
    input wire bus_in_s i_bus,
    input wire logic i_bus_rst_n,
    // User control
    input wire logic i_want_bus,
    input wire logic i_claim,
    input wire logic i_is_master,
    input wire logic i_receiving,
    input wire logic i_special,
    input wire logic i_perr_en,
    input wire logic i_serr_en,
    input wire logic i_addr_perr,
    input wire logic i_sys_err,
    // Pin drivers
    output pin_out_s o_pins,
    // Status
    output logic o_granted,
    output logic o_dperr
);

    logic bus_rst_n_s;
    logic bus_rst;
    bus_in_s smp_r;
    bus_in_s smp_nxt;
    logic done_w;
    logic qual_w;
    logic chk_r;
    logic chk_nxt;
    logic spc_r;
    logic spc_nxt;
    logic calc_par_r;
    logic calc_par_nxt;
    logic mismatch_w;
    logic err_w;
    logic spc_err_w;
    sts_state_e perr_st_r;
    sts_state_e perr_st_nxt;
    sts_state_e ds_st_r;
    sts_state_e ds_st_nxt;
    logic serr_evt;
    logic serr_fire;
    logic serr_pend_r;
    logic serr_pend_nxt;
    logic [`SERR_GAP_W-1:0] gap_r;
    logic [`SERR_GAP_W-1:0] gap_nxt;
    pin_out_s pins_r;
    pin_out_s pins_nxt;
    logic granted_r;
    logic granted_nxt;
    logic dperr_r;
    logic dperr_nxt;

    // Bus reset pin is asynchronous, so it is filtered first
    // Three stages cost about four clocks of latency on entry and exit
    pci_err_sync u_rst_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_async(i_bus_rst_n),
        .o_level(bus_rst_n_s)
    );

    assign bus_rst = !bus_rst_n_s;

    // Sample the bused pins once per edge
    always_comb begin
        smp_nxt = i_bus;
    end

    // Completion and qualification of the sampled data phase
    assign done_w = !smp_r.irdy_n && !smp_r.trdy_n;
    assign qual_w = i_receiving && (i_is_master || (pins_r.devsel_oe && !pins_r.devsel_n));

    // Stage one: remember the phase and its computed parity
    // Qualifiers are taken a clock after the bus edge, so the user
    // must hold them through the data phase
    always_comb begin
        chk_nxt = done_w && qual_w && !i_special && !bus_rst;
        spc_nxt = done_w && i_special && !bus_rst;
        calc_par_nxt = ^{smp_r.ad, smp_r.cbe_n};
    end

    // Parity arrives one clock after its data
    assign mismatch_w = calc_par_r ^ smp_r.par;
    assign err_w = chk_r && mismatch_w;
    assign spc_err_w = spc_r && mismatch_w;

    // Parity error driver: low per bad phase, high one clock, then float
    // A new error in the high clock goes straight back to low, so a run
    // of bad phases with one gap never floats in between
    always_comb begin
        perr_st_nxt = perr_st_r;
        if (bus_rst) begin
            perr_st_nxt = ST_IDLE;
        end else if (err_w && i_perr_en) begin
            perr_st_nxt = ST_LOW;
        end else begin
            case (perr_st_r)
                ST_LOW: perr_st_nxt = ST_HIGH;
                ST_HIGH: perr_st_nxt = ST_IDLE;
                default: perr_st_nxt = ST_IDLE;
            endcase
        end
    end

    // Device select driver; a claim drives it low, release goes high first
    always_comb begin
        ds_st_nxt = ds_st_r;
        if (bus_rst) begin
            ds_st_nxt = ST_IDLE;
        end else if (i_claim) begin
            ds_st_nxt = ST_LOW;
        end else begin
            case (ds_st_r)
                ST_LOW: ds_st_nxt = ST_HIGH;
                ST_HIGH: ds_st_nxt = ST_IDLE;
                default: ds_st_nxt = ST_IDLE;
            endcase
        end
    end

    // System error: events wait until the pull-up has had time to restore
    // the line, so two reports never merge into one long low pulse
    assign serr_evt = (i_addr_perr || i_sys_err || spc_err_w) && i_serr_en;
    assign serr_fire = serr_pend_r && (gap_r == '0) && !bus_rst;

    always_comb begin
        serr_pend_nxt = serr_pend_r;
        gap_nxt = gap_r;
        if (bus_rst) begin
            serr_pend_nxt = 1'b0;
        end else begin
            // A new event wins over the clear of the one being sent
            serr_pend_nxt = (serr_pend_r && !serr_fire) || serr_evt;
        end
        if (serr_fire) begin
            gap_nxt = `SERR_GAP_W'(`SERR_PULLUP_CLKS);
        end else if (gap_r != '0) begin
            gap_nxt = gap_r - `SERR_GAP_W'(1);
        end
    end

    // Pin drivers, all changing on clock edges
    // Enables are registered with their values, so a pin never glitches
    // between driven and floating
    always_comb begin
        pins_nxt.req_oe = !bus_rst;
        pins_nxt.req_n = !i_want_bus;
        pins_nxt.devsel_oe = ds_st_nxt != ST_IDLE;
        pins_nxt.devsel_n = ds_st_nxt != ST_LOW;
        pins_nxt.perr_oe = perr_st_nxt != ST_IDLE;
        pins_nxt.perr_n = perr_st_nxt != ST_LOW;
        pins_nxt.serr_oe = serr_fire;
        pins_nxt.serr_n = 1'b0; // Open drain: only ever drives low
        granted_nxt = !bus_rst && !smp_r.gnt_n;
        dperr_nxt = err_w;
    end

    // Registers
    // Sampled pins reset to idle, so no phase completes out of reset
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            smp_r <= {$bits(bus_in_s){`BUS_IDLE_BIT}};
            chk_r <= 1'b0;
            spc_r <= 1'b0;
            calc_par_r <= 1'b0;
            perr_st_r <= ST_IDLE;
            ds_st_r <= ST_IDLE;
            serr_pend_r <= 1'b0;
            gap_r <= '0;
            pins_r <= '{req_n: 1'b1, req_oe: 1'b0, devsel_n: 1'b1, devsel_oe: 1'b0,
                        perr_n: 1'b1, perr_oe: 1'b0, serr_n: 1'b0, serr_oe: 1'b0};
            granted_r <= 1'b0;
            dperr_r <= 1'b0;
        end else begin
            smp_r <= smp_nxt;
            chk_r <= chk_nxt;
            spc_r <= spc_nxt;
            calc_par_r <= calc_par_nxt;
            perr_st_r <= perr_st_nxt;
            ds_st_r <= ds_st_nxt;
            serr_pend_r <= serr_pend_nxt;
            gap_r <= gap_nxt;
            pins_r <= pins_nxt;
            granted_r <= granted_nxt;
            dperr_r <= dperr_nxt;
        end
    end

    assign o_pins = pins_r;
    assign o_granted = granted_r;
    assign o_dperr = dperr_r;

    // Checks
    // All of them rest while the block is held in reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    chk_req_float: assert property (
        bus_rst ##1 bus_rst |-> !o_pins.req_oe)
        else $error("request pin driven during bus reset");

    chk_gnt_ignored: assert property (
        bus_rst |=> !o_granted)
        else $error("grant seen during bus reset");

    chk_perr_slot: assert property (
        (done_w && qual_w && !i_special && !bus_rst) ##1 (mismatch_w && i_perr_en && !bus_rst)
        |=> (o_pins.perr_oe && !o_pins.perr_n))
        else $error("parity error not driven two clocks after data");

    chk_perr_run: assert property (
        (err_w && i_perr_en && !bus_rst) ##1 (err_w && i_perr_en && !bus_rst)
        |=> (!o_pins.perr_n && o_pins.perr_oe) ##0 !$past(o_pins.perr_n))
        else $error("parity error broken across bad phases");

    chk_perr_release: assert property (
        (o_pins.perr_oe && !o_pins.perr_n) ##1 (!o_pins.perr_oe || o_pins.perr_n)
        |-> (o_pins.perr_oe && o_pins.perr_n) || !bus_rst_n_s)
        else $error("parity error floated without driving high");

    chk_perr_special: assert property (
        $fell(o_pins.perr_n) |-> $past(err_w) && !$past(spc_r))
        else $error("parity error for a special cycle");

    chk_perr_claim: assert property (
        chk_r |-> ($past(i_is_master) || ($past(pins_r.devsel_oe) && !$past(pins_r.devsel_n))))
        else $error("parity error without claim or mastership");

    chk_serr_one: assert property (
        o_pins.serr_oe |-> !o_pins.serr_n ##1 !o_pins.serr_oe [*3])
        else $error("system error not a single low clock");

    chk_serr_enable: assert property (
        $rose(serr_pend_r) |-> $past(i_serr_en))
        else $error("system error queued while disabled");

    chk_devsel_claim: assert property (
        (i_claim && !bus_rst) |=> (o_pins.devsel_oe && !o_pins.devsel_n))
        else $error("claim did not drive device select");

    // Outside bus reset the request pin is driven and follows the user
    chk_req_follow: assert property (
        !bus_rst |=> (o_pins.req_oe && (o_pins.req_n == !$past(i_want_bus))))
        else $error("request pin not following the user");

    // Outside bus reset a sampled grant is passed on
    chk_gnt_follow: assert property (
        (!bus_rst && !smp_r.gnt_n) |=> o_granted)
        else $error("grant not passed on");

    // Bus reset leaves every error and select pin floating
    chk_bus_rst_quiet: assert property (
        bus_rst |=> !(o_pins.perr_oe || o_pins.devsel_oe || o_pins.serr_oe))
        else $error("pin driven during bus reset");

    // A qualifying bad phase is always reported, enable or not
    chk_dperr_pulse: assert property (
        (done_w && qual_w && !i_special && !bus_rst) ##1 mismatch_w |=> o_dperr)
        else $error("data parity error dropped");

    // A special-cycle phase never raises the data parity report
    chk_special_silent: assert property (
        (done_w && i_special && !bus_rst) ##1 mismatch_w |=> !o_dperr)
        else $error("data parity report for a special cycle");

    // Parity error low only with reporting enabled
    chk_perr_enable: assert property (
        (o_pins.perr_oe && !o_pins.perr_n) |-> $past(i_perr_en))
        else $error("parity error driven while disabled");

    // A system error is queued only from one of its three sources
    chk_serr_source: assert property (
        $rose(serr_pend_r) |-> ($past(i_addr_perr) || $past(i_sys_err) || $past(spc_err_w)))
        else $error("system error without a source");

endmodule

// *** pci_err_arbiter.sv ***
// Purpose: Central arbiter and system error collector beside the agent
// Assumes: Pin levels arrive already resolved with their pull-ups
// Notes: i_rogue forces a grant so the agent can be provoked in bus reset
module pci_err_arbiter (
    // Clock and bus reset
    input wire logic i_clk,
    input wire logic i_bus_rst_n,
    // Resolved pin levels and misbehaviour switch
    input wire logic i_req_n,
    input wire logic i_serr_n,
    input wire logic i_rogue,
    // Grant and report count
    output logic o_gnt_n,
    output int o_serr_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gnt_r;

    // Floating requests mean nothing in reset, so no grant before it ends unless i_rogue forces one
    always_ff @(posedge i_clk or negedge i_bus_rst_n) begin
        if (!i_bus_rst_n) begin
            gnt_r <= 1'b1;
        end else begin
            gnt_r <= i_req_n;
        end
    end
    assign o_gnt_n = i_rogue ? 1'b0 : gnt_r;

    // Each clock the line is seen low outside bus reset raises one report
    initial o_serr_seen = 0;
    always @(posedge i_clk) begin
        if (i_bus_rst_n && !i_serr_n) begin
            o_serr_seen <= o_serr_seen + 1;
        end
    end
endmodule

// *** test_pci_err_agent.sv ***
// Purpose: Self-checking bench of the PCI request and error-report agent
// Assumes: Inputs change at the falling edge; pins resolve to pull-ups
// Notes: Error pulses are paired in order with notes from the driver
module test_pci_err_agent
    import pci_err_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
    logic i_clk, i_resetn, i_bus_rst_n, i_want_bus, i_claim, i_is_master, i_receiving;
    logic i_special, i_perr_en, i_serr_en, i_addr_perr, i_sys_err, rogue;
    logic o_granted, o_dperr, gnt_n, req_line, serr_line;
    bus_in_s b, bus_v;
    pin_out_s o_pins;
    int err_total, n_compared, serr_seen, serr_exp;
    logic [1:0] exp_q[$];
    logic [1:0] note;
    logic [31:0] seed;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Free-running 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Undriven pins rest at their pull-up level
    assign req_line = o_pins.req_oe ? o_pins.req_n : 1'b1;
    assign serr_line = o_pins.serr_oe ? o_pins.serr_n : 1'b1;
    always_comb begin
        bus_v = b;
        bus_v.gnt_n = gnt_n;
    end

    pci_err_agent i_pci_err_agent (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus(bus_v),
        .i_bus_rst_n(i_bus_rst_n), .i_want_bus(i_want_bus), .i_claim(i_claim),
        .i_is_master(i_is_master), .i_receiving(i_receiving), .i_special(i_special),
        .i_perr_en(i_perr_en), .i_serr_en(i_serr_en), .i_addr_perr(i_addr_perr),
        .i_sys_err(i_sys_err), .o_pins(o_pins), .o_granted(o_granted), .o_dperr(o_dperr));
    pci_err_arbiter i_pci_err_arbiter (.i_clk(i_clk), .i_bus_rst_n(i_bus_rst_n), .i_req_n(req_line),
        .i_serr_n(serr_line), .i_rogue(rogue), .o_gnt_n(gnt_n), .o_serr_seen(serr_seen));

    // Each error pulse takes the oldest note; a pulse with no note is a fault
    always @(posedge i_clk) begin
        #1;
        if (o_dperr === 1'b1 || o_pins.serr_oe === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 2'b00;
            `CMP({o_dperr, o_pins.serr_oe}, note)
        end
    end

    // Back-to-back data phases; the pin is checked three falls after each
    task automatic phases(input int n, input logic [3:0] bad);
        logic q, pp, low, was_low;
        logic [31:0] d;
        logic [3:0] c;
        q = (i_is_master | i_claim) & i_receiving & !i_special;
        was_low = 1'b0;
        pp = 1'b0;
        for (int i = 0; i < n + 5; i++) begin
            @(negedge i_clk);
            if (i >= 3) begin
                low = (i - 3 < n) && bad[i-3] && q && i_perr_en;
                `CMP({o_pins.perr_oe, o_pins.perr_n}, {low | was_low, !low})
                was_low = low;
            end
            b.par = pp;
            if (i < n) begin
                d = rnd();
                c = 4'(rnd());
                b.ad = d;
                b.cbe_n = c;
                b.irdy_n = 1'b0;
                b.trdy_n = 1'b0;
                pp = ^{d, c} ^ bad[i];
                if (bad[i] && q) exp_q.push_back(2'b10);
                if (bad[i] && i_special) begin
                    exp_q.push_back(2'b01);
                    serr_exp++;
                end
            end else begin
                b.irdy_n = 1'b1;
                b.trdy_n = 1'b1;
            end
        end
    endtask

    task summarize();
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        seed = 32'h1ba0b8b1;
        {err_total, n_compared, serr_exp} = '0;
        {i_resetn, i_bus_rst_n, i_want_bus, i_claim, i_is_master, i_receiving} = '0;
        {i_special, i_perr_en, i_serr_en, i_addr_perr, i_sys_err} = '0;
        rogue = 1'b1;
        b = '1;
        repeat (2) @(negedge i_clk);
        i_resetn = 1'b1;
        i_want_bus = 1'b1;
        i_claim = 1'b1;
        repeat (6) @(negedge i_clk);
        `CMP({o_pins.req_oe, o_granted, o_pins.devsel_oe, o_pins.serr_oe}, 4'h0)
        rogue = 1'b0;
        i_bus_rst_n = 1'b1;
        i_claim = 1'b0;
        repeat (8) @(negedge i_clk);
        `CMP({o_pins.req_oe, o_pins.req_n, o_granted}, 3'b101)
        i_want_bus = 1'b0;
        repeat (4) @(negedge i_clk);
        `CMP({o_pins.req_n, o_granted}, 2'b10)
        {i_is_master, i_receiving, i_perr_en, i_serr_en} = 4'hf;
        phases(1, 4'b0001);
        phases(4, 4'b0111);
        phases(4, 4'b1010);
        i_perr_en = 1'b0;
        phases(2, 4'b0011);
        i_perr_en = 1'b1;
        i_is_master = 1'b0;
        phases(2, 4'b0011);
        i_claim = 1'b1;
        repeat (2) @(negedge i_clk);
        `CMP({o_pins.devsel_oe, o_pins.devsel_n}, 2'b10)
        phases(2, 4'b0001);
        i_claim = 1'b0;
        i_is_master = 1'b1;
        i_special = 1'b1;
        phases(1, 4'b0001);
        i_special = 1'b0;
        repeat (4) @(negedge i_clk);
        // Fatal, address parity and disabled fatal events in turn
        for (int k = 0; k < 3; k++) begin
            i_sys_err = (k != 1);
            i_addr_perr = (k == 1);
            i_serr_en = (k != 2);
            if (k != 2) begin
                exp_q.push_back(2'b01);
                serr_exp++;
            end
            @(negedge i_clk);
            i_sys_err = 1'b0;
            i_addr_perr = 1'b0;
            // The event is queued on one edge and reaches the pin on the next
            @(negedge i_clk);
            `CMP({o_pins.serr_oe, o_pins.serr_n}, {k != 2, 1'b0})
            @(negedge i_clk);
            `CMP(o_pins.serr_oe, 1'b0)
            repeat (4) @(negedge i_clk);
        end
        // Bus reset in mid-run: request floats, a forced grant is ignored
        i_want_bus = 1'b1;
        rogue = 1'b1;
        i_bus_rst_n = 1'b0;
        repeat (6) @(negedge i_clk);
        `CMP({o_pins.req_oe, o_granted}, 2'b00)
        `CMP(exp_q.size(), 0)
        `CMP(serr_seen, serr_exp)
        summarize();
    end

    // Watchdog well beyond the expected hundred or so clocks
    initial begin
        #20000;
        err_total++;
        summarize();
    end
endmodule
